//--- hdl/agc_defines.vh
// Register map, field positions, reset values and timing counts of the gain engine.
// Assumes the includer runs on a 250 MHz ref_clk.
`ifndef AGC_DEFINES_VH
`define AGC_DEFINES_VH

`define AGC_ADDR_CFG1        7'h10
`define AGC_ADDR_CFG2        7'h11
`define AGC_ADDR_RAMP        7'h12
`define AGC_ADDR_LIMW        7'h14
`define AGC_ADDR_RESET       7'h17

`define AGC_RST_CFG1         9'h07B
`define AGC_RST_CFG2         9'h000
`define AGC_RST_RAMP         9'h032
`define AGC_RST_LIMW         9'h0A6

`define AGC_SEL_MSB          8
`define AGC_SEL_LSB          7
`define AGC_CEIL_MSB         6
`define AGC_CEIL_LSB         4
`define AGC_EN_BIT           8
`define AGC_ZC_BIT           7
`define AGC_HOLD_MSB         3
`define AGC_HOLD_LSB         0
`define AGC_DCY_MSB          7
`define AGC_DCY_LSB          4
`define AGC_ATK_MSB          3
`define AGC_ATK_LSB          0
`define AGC_WIN_MSB          6
`define AGC_WIN_LSB          4
`define AGC_FLOOR_MSB        3
`define AGC_FLOOR_LSB        0

`define AGC_SEL_LIMITER      2'h0
`define AGC_SEL_RIGHT        2'h1
`define AGC_SEL_LEFT         2'h2
`define AGC_SEL_STEREO       2'h3

`define AGC_CODE_SAT         4'hA

// Gain codes: 0.5 dB per code, 0xCF = 0 dB, 0xFF = +24 dB, 0xA5 = -21 dB
`define AGC_GAIN_0DB         8'hCF
`define AGC_GAIN_MAX         8'hFF
`define AGC_GAIN_MIN         8'hA5
`define AGC_STEP_DB_X2       8'h01

// Times in ns, as printed; one step of 0.5 dB per interval
`define AGC_CLK_NS           4
`define AGC_ALC_ATK_NS       8400000
`define AGC_ALC_DCY_NS       33600000
`define AGC_LIM_ATK_NS       250000
`define AGC_LIM_DCY_NS       1200000
`define AGC_WIN_BASE_NS      62500
`define AGC_HOLD_BASE_NS     2670000
// ALC traverses 90% of 90 steps = 81 steps; limiter 6 dB = 12 steps
`define AGC_ALC_STEPS        81
`define AGC_LIM_STEPS        12
`define AGC_ALC_ATK_CYC      (`AGC_ALC_ATK_NS / `AGC_CLK_NS / `AGC_ALC_STEPS)
`define AGC_ALC_DCY_CYC      (`AGC_ALC_DCY_NS / `AGC_CLK_NS / `AGC_ALC_STEPS)
`define AGC_LIM_ATK_CYC      (`AGC_LIM_ATK_NS / `AGC_CLK_NS / `AGC_LIM_STEPS)
`define AGC_LIM_DCY_CYC      (`AGC_LIM_DCY_NS / `AGC_CLK_NS / `AGC_LIM_STEPS)
`define AGC_WIN_BASE_CYC     (`AGC_WIN_BASE_NS / `AGC_CLK_NS)
`define AGC_HOLD_BASE_CYC    (`AGC_HOLD_BASE_NS / `AGC_CLK_NS)

`endif

//--- hdl/agc_interval_timer.v
// Free up-counter that pulses once per interval of base << shift cycles.
// Assumes base and shift are stable or that a restart follows a change.
`timescale 1ns/1ns
`default_nettype none
module agc_interval_timer (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        restart,
	input  wire [31:0] base,
	input  wire [3:0]  shift,
	output reg         tick
);
	reg  [39:0] count;
	wire [39:0] span = {8'h00, base} << shift;

	always @(posedge ref_clk) begin
		if (rst || restart) begin
			count <= 40'h00_0000_0000;
			tick  <= 1'b0;
		end else if (count + 40'h00_0000_0001 >= span) begin
			count <= 40'h00_0000_0000;
			tick  <= 1'b1;
		end else begin
			count <= count + 40'h00_0000_0001;
			tick  <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- hdl/agc_gain_engine.v
// Automatic gain engine: peak limiter or automatic level control for the PGA.
// Assumes peak flags come from a detector on ref_clk; register writes
// arrive as a one-cycle strobe with 7-bit address and 9-bit data.
`timescale 1ns/1ns
`default_nettype none
`include "agc_defines.vh"
module agc_gain_engine (
	input  wire       ref_clk,
	input  wire       rst,
	input  wire       reg_wr,
	input  wire [6:0] reg_addr,
	input  wire [8:0] reg_wdata,
	input  wire [6:0] reg_raddr,
	output reg  [8:0] reg_rdata,
	input  wire [7:0] static_gain_left,
	input  wire [7:0] static_gain_right,
	input  wire       peak_over_left,
	input  wire       peak_over_right,
	input  wire       overload_left,
	input  wire       overload_right,
	input  wire       zero_cross_left,
	input  wire       zero_cross_right,
	output reg  [7:0] pga_gain_left,
	output reg  [7:0] pga_gain_right,
	output reg        ramping_down,
	output reg        ramping_up
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_DOWN = 4'b0010;
	localparam ST_HOLD = 4'b0100;
	localparam ST_UP   = 4'b1000;

	reg  [8:0] level_control_config_one;
	reg  [8:0] level_control_config_two;
	reg  [8:0] gain_ramp_timing;
	reg  [8:0] limiter_window_attenuation;
	reg  [3:0] state;
	reg  [3:0] next_state;

	// Pin inputs pass two flops; index 0 is only read by index 1
	reg  [5:0] sync_a;
	reg  [5:0] sync_b;
	wire [5:0] raw_in = {zero_cross_right, zero_cross_left, overload_right,
		overload_left, peak_over_right, peak_over_left};
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
			always @(posedge ref_clk) begin
				if (rst) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
				end else begin
					sync_a[gi] <= raw_in[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	wire [1:0] gain_control_function_sel =
		level_control_config_one[`AGC_SEL_MSB:`AGC_SEL_LSB];
	wire [2:0] gain_ceiling =
		level_control_config_one[`AGC_CEIL_MSB:`AGC_CEIL_LSB];
	wire       gain_control_enable = level_control_config_two[`AGC_EN_BIT];
	wire       auto_level_zero_cross_en = level_control_config_two[`AGC_ZC_BIT];
	wire [3:0] ramp_up_hold_time =
		level_control_config_two[`AGC_HOLD_MSB:`AGC_HOLD_LSB];
	wire [3:0] decay_time_code = gain_ramp_timing[`AGC_DCY_MSB:`AGC_DCY_LSB];
	wire [3:0] attack_time_code = gain_ramp_timing[`AGC_ATK_MSB:`AGC_ATK_LSB];
	wire [2:0] transient_window_len =
		limiter_window_attenuation[`AGC_WIN_MSB:`AGC_WIN_LSB];
	wire [3:0] gain_floor_limit =
		limiter_window_attenuation[`AGC_FLOOR_MSB:`AGC_FLOOR_LSB];

	wire limiter = (gain_control_function_sel == `AGC_SEL_LIMITER);
	wire use_left  = gain_control_function_sel[1] || limiter;
	wire use_right = gain_control_function_sel[0] || limiter;

	// Codes at or above 1010 all select the longest time
	function [3:0] agc_sat_code;
		input [3:0] code;
		begin
			agc_sat_code = (code >= `AGC_CODE_SAT) ? `AGC_CODE_SAT : code;
		end
	endfunction

	// Limiter floor in half-dB codes below static: 0011 or lower is -3dB
	function [7:0] agc_lim_floor_steps;
		input [3:0] code;
		begin
			if (code <= 4'h3)
				agc_lim_floor_steps = 8'h06;
			else if (code >= 4'hC)
				agc_lim_floor_steps = 8'h18;
			else
				agc_lim_floor_steps = {3'h0, code, 1'b0};
		end
	endfunction

	// Level control absolute floor: -1dB, -5dB..-17dB in 4dB, 1111 -21dB
	function [7:0] agc_alc_floor;
		input [3:0] code;
		begin
			case (code)
				4'hB:    agc_alc_floor = `AGC_GAIN_0DB - 8'h0A;
				4'hC:    agc_alc_floor = `AGC_GAIN_0DB - 8'h12;
				4'hD:    agc_alc_floor = `AGC_GAIN_0DB - 8'h1A;
				4'hE:    agc_alc_floor = `AGC_GAIN_0DB - 8'h22;
				4'hF:    agc_alc_floor = `AGC_GAIN_MIN;
				default: agc_alc_floor = `AGC_GAIN_0DB - 8'h02;
			endcase
		end
	endfunction

	// Ceiling: 111 +24dB falling 4dB per code, 001 and 000 give 0dB
	function [7:0] agc_ceiling;
		input [2:0] code;
		begin
			if (code <= 3'h1)
				agc_ceiling = `AGC_GAIN_0DB;
			else
				agc_ceiling = `AGC_GAIN_0DB + {2'h0, code - 3'h1, 3'h0};
		end
	endfunction

	wire [7:0] static_max = (static_gain_left > static_gain_right) ?
		static_gain_left : static_gain_right;
	wire [7:0] lim_steps = agc_lim_floor_steps(gain_floor_limit);
	wire [7:0] lim_floor = (static_max > `AGC_GAIN_MIN + lim_steps) ?
		static_max - lim_steps : `AGC_GAIN_MIN;
	wire [7:0] floor_gain = limiter ? lim_floor :
		agc_alc_floor(gain_floor_limit);
	// Limiter tops out at static gain; the ceiling is level control only
	wire [7:0] ceil_gain = limiter ? static_max :
		agc_ceiling(gain_ceiling);

	wire over_l = sync_b[0] && use_left;
	wire over_r = sync_b[1] && use_right;
	wire peak_over = over_l || over_r;
	wire overload = !limiter && ((sync_b[2] && use_left) ||
		(sync_b[3] && use_right));
	wire zc_seen = (use_left && sync_b[4]) || (use_right && sync_b[5]);
	wire zc_ok = limiter || !auto_level_zero_cross_en || zc_seen;

	// Transient window: count over-threshold cycles before limiter acts
	reg  [19:0] win_count;
	// Base window in cycles; 20 bits still hold the longest window
	// of 1,000,000 cycles, so the upper bits are cut on purpose
	wire [31:0] win_base = `AGC_WIN_BASE_CYC;
	wire [19:0] win_span = (transient_window_len == 3'h0) ? 20'h0_0000 :
		(win_base[19:0] << (transient_window_len - 3'h1));
	wire win_done = (win_count >= win_span);
	always @(posedge ref_clk) begin
		if (rst || !peak_over || !limiter)
			win_count <= 20'h0_0000;
		else if (!win_done)
			win_count <= win_count + 20'h0_0001;
	end
	wire go_down = peak_over && (!limiter || win_done);

	// Step interval select per mode and direction
	wire [3:0] atk_eff = overload ? 4'h0 : agc_sat_code(attack_time_code);
	wire [3:0] dcy_eff = agc_sat_code(decay_time_code);
	reg  [31:0] step_base;
	reg  [3:0]  step_shift;
	always @* begin
		step_base  = 32'h0000_0000;
		step_shift = 4'h0;
		if (state == ST_DOWN) begin
			step_shift = atk_eff;
			step_base  = limiter ? `AGC_LIM_ATK_CYC :
				`AGC_ALC_ATK_CYC;
		end else begin
			step_shift = dcy_eff;
			step_base  = limiter ? `AGC_LIM_DCY_CYC :
				`AGC_ALC_DCY_CYC;
		end
	end

	wire step_tick;
	wire [31:0] hold_base = `AGC_HOLD_BASE_CYC;
	reg  [39:0] hold_count;
	wire [39:0] hold_span = (ramp_up_hold_time == 4'h0) ? 40'h00_0000_0000 :
		({8'h00, hold_base} << (ramp_up_hold_time - 4'h1));
	wire hold_done = limiter || (hold_count >= hold_span);

	agc_interval_timer u_step (
		.ref_clk (ref_clk),
		.rst     (rst),
		.restart (state != next_state),
		.base    (step_base),
		.shift   (step_shift),
		.tick    (step_tick)
	);

	wire [7:0] ref_gain = use_left ? pga_gain_left : pga_gain_right;
	wire active = gain_control_enable;
	wire want_up = (ref_gain < ceil_gain);

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (!active)
					next_state = ST_IDLE;
				else if (go_down || overload)
					next_state = ST_DOWN;
				else if (want_up)
					next_state = ST_HOLD;
			end
			ST_DOWN: begin
				if (!active)
					next_state = ST_IDLE;
				else if (!go_down && !overload)
					next_state = ST_HOLD;
			end
			ST_HOLD: begin
				if (!active)
					next_state = ST_IDLE;
				else if (go_down || overload)
					next_state = ST_DOWN;
				else if (hold_done)
					next_state = ST_UP;
			end
			ST_UP: begin
				if (!active)
					next_state = ST_IDLE;
				else if (go_down || overload)
					next_state = ST_DOWN;
				else if (!want_up)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge ref_clk) begin
		if (rst || state != ST_HOLD)
			hold_count <= 40'h00_0000_0000;
		else if (!hold_done)
			hold_count <= hold_count + 40'h00_0000_0001;
	end

	// Gain moves one half-dB code per step tick, gated by zero crossing in level control only
	wire do_step = step_tick && zc_ok;
	reg  [7:0] next_left;
	reg  [7:0] next_right;
	always @* begin
		next_left  = use_left ? pga_gain_left : static_gain_left;
		next_right = use_right ? pga_gain_right : static_gain_right;
		if (!active) begin
			next_left  = static_gain_left;
			next_right = static_gain_right;
		end else if (do_step && state == ST_DOWN && ref_gain > floor_gain) begin
			if (use_left)
				next_left = pga_gain_left - `AGC_STEP_DB_X2;
			if (use_right)
				next_right = pga_gain_right - `AGC_STEP_DB_X2;
		end else if (do_step && state == ST_UP && want_up) begin
			if (use_left)
				next_left = pga_gain_left + `AGC_STEP_DB_X2;
			if (use_right)
				next_right = pga_gain_right + `AGC_STEP_DB_X2;
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			state          <= ST_IDLE;
			pga_gain_left  <= `AGC_GAIN_0DB;
			pga_gain_right <= `AGC_GAIN_0DB;
			ramping_down   <= 1'b0;
			ramping_up     <= 1'b0;
		end else begin
			state          <= next_state;
			pga_gain_left  <= next_left;
			pga_gain_right <= next_right;
			ramping_down   <= (next_state == ST_DOWN);
			ramping_up     <= (next_state == ST_UP);
		end
	end

	// Register file; a write to the reset address restores defaults
	always @(posedge ref_clk) begin
		if (rst || (reg_wr && reg_addr == `AGC_ADDR_RESET)) begin
			level_control_config_one   <= `AGC_RST_CFG1;
			level_control_config_two   <= `AGC_RST_CFG2;
			gain_ramp_timing           <= `AGC_RST_RAMP;
			limiter_window_attenuation <= `AGC_RST_LIMW;
		end else if (reg_wr) begin
			case (reg_addr)
				`AGC_ADDR_CFG1: level_control_config_one <= reg_wdata;
				`AGC_ADDR_CFG2: level_control_config_two <= reg_wdata;
				`AGC_ADDR_RAMP: gain_ramp_timing <= reg_wdata;
				`AGC_ADDR_LIMW: limiter_window_attenuation <= reg_wdata;
				default: ;
			endcase
		end
	end

	always @(posedge ref_clk) begin
		if (rst)
			reg_rdata <= 9'h000;
		else begin
			case (reg_raddr)
				`AGC_ADDR_CFG1: reg_rdata <= level_control_config_one;
				`AGC_ADDR_CFG2: reg_rdata <= level_control_config_two;
				`AGC_ADDR_RAMP: reg_rdata <= gain_ramp_timing;
				`AGC_ADDR_LIMW: reg_rdata <= limiter_window_attenuation;
				default:        reg_rdata <= 9'h000;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- testbench/agc_gain_engine_monitor.sv
// Port assertions for the gain engine.
// Assumes bind onto agc_gain_engine, one clock domain on ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "agc_defines.vh"
module agc_gain_engine_monitor (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       reg_wr,
	input wire logic [6:0] reg_addr,
	input wire logic [8:0] reg_wdata,
	input wire logic [6:0] reg_raddr,
	input wire logic [8:0] reg_rdata,
	input wire logic [7:0] pga_gain_left,
	input wire logic       ramping_down,
	input wire logic       ramping_up
);
	logic [15:0] gap;
	logic [7:0]  prev_gain;
	logic        prev_dn;

	// Cycles since the last left gain or down-flag change; saturates
	always @(posedge ref_clk) begin
		prev_gain <= pga_gain_left;
		prev_dn   <= ramping_down;
		if (rst || pga_gain_left != prev_gain || ramping_down != prev_dn)
			gap <= 16'h0000;
		else if (gap != 16'hFFFF)
			gap <= gap + 16'h0001;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence ramp_write;
		reg_wr && reg_addr == `AGC_ADDR_RAMP && !reg_wdata[8] ##1 !reg_wr;
	endsequence
	sequence addr_hold;
		!reg_wr ##1 $stable(reg_raddr);
	endsequence

	a_reset_state: assert property (disable iff (1'b0)
		rst |=> pga_gain_left == `AGC_GAIN_0DB && !ramping_down && !ramping_up)
		else $error("gain or flags not at reset value");
	a_unmapped_zero: assert property (
		!(reg_raddr inside {7'h10, 7'h11, 7'h12, 7'h14})
		|=> reg_rdata == 9'h000)
		else $error("unmapped read not zero");
	a_ramp_readback: assert property (
		ramp_write ##1 reg_raddr == `AGC_ADDR_RAMP
		|=> reg_rdata == $past(reg_wdata, 3))
		else $error("ramp timing readback wrong");
	a_rdata_stands: assert property (addr_hold |=> $stable(reg_rdata))
		else $error("read data moved without cause");
	a_flags_exclusive: assert property (!(ramping_down && ramping_up))
		else $error("both ramp flags high");
	a_step_size: assert property (
		($past(ramping_down) || $past(ramping_up)) &&
		pga_gain_left != $past(pga_gain_left)
		|-> (pga_gain_left - $past(pga_gain_left) == 8'h01) ||
		($past(pga_gain_left) - pga_gain_left == 8'h01))
		else $error("gain step not one code");
	a_down_needs_flag: assert property (
		pga_gain_left < $past(pga_gain_left) |-> $past(ramping_down))
		else $error("gain fell outside down state");
	a_step_spacing: assert property (
		ramping_down && $past(ramping_down) &&
		pga_gain_left != $past(pga_gain_left) |-> gap >= 16'd5000)
		else $error("down steps too close");
endmodule
bind agc_gain_engine agc_gain_engine_monitor agc_gain_engine_monitor_i (
	.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata),
	.pga_gain_left(pga_gain_left), .ramping_down(ramping_down),
	.ramping_up(ramping_up));
`default_nettype wire

//--- testbench/limiter_alc_gain_timing_test.sv
// Self-checking bench for the gain engine: registers, limiter, level control.
// Assumes a 250 MHz ref_clk; zero-cross inputs stay low (gating is off).
`timescale 1ns/1ns
`default_nettype none
`include "agc_defines.vh"
module limiter_alc_gain_timing_test;
	logic       ref_clk, rst, reg_wr, ramping_down, ramping_up;
	logic [6:0] reg_addr, reg_raddr;
	logic [8:0] reg_wdata, reg_rdata;
	logic [7:0] static_gain_left, static_gain_right;
	logic [7:0] pga_gain_left, pga_gain_right;
	logic       peak_over_left, peak_over_right;
	logic       overload_left, overload_right;
	logic       zero_cross_left, zero_cross_right;
	int         checked, miscompares;
	logic [6:0] ra [6] = '{7'h10, 7'h11, 7'h12, 7'h14, 7'h13, 7'h7F};
	logic [8:0] rv [6] = '{`AGC_RST_CFG1, `AGC_RST_CFG2, `AGC_RST_RAMP,
		`AGC_RST_LIMW, 9'h000, 9'h000};

	agc_gain_engine agc_gain_engine_i (
		.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata),
		.static_gain_left(static_gain_left),
		.static_gain_right(static_gain_right),
		.peak_over_left(peak_over_left), .peak_over_right(peak_over_right),
		.overload_left(overload_left), .overload_right(overload_right),
		.zero_cross_left(zero_cross_left),
		.zero_cross_right(zero_cross_right),
		.pga_gain_left(pga_gain_left), .pga_gain_right(pga_gain_right),
		.ramping_down(ramping_down), .ramping_up(ramping_up));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task chk(input string name, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s exp %h got %h", name, e, g);
		end
	endtask

	// Cycle counts are compared against an allowed span
	task chk_span(input string name, input int lo, input int hi, input int g);
		checked++;
		if (g < lo || g > hi) begin
			miscompares++;
			$display("wrong value %s exp %0d to %0d got %0d", name, lo, hi, g);
		end
	endtask

	// Holds the strobe one cycle, then idles one so calls can follow at once
	task wr(input logic [6:0] a, input logic [8:0] d);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask

	task rd(input logic [6:0] a, input logic [8:0] e);
		reg_raddr <= a;
		repeat (3) @(posedge ref_clk);
		chk("read data", {7'h00, e}, {7'h00, reg_rdata});
	endtask

	task count_until_change(input logic [7:0] g0, input int lim, output int n);
		n = 0;
		while (pga_gain_left === g0 && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
	endtask

	task end_sim;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Main sequence needs about 57000 cycles
	initial begin
		repeat (80000) @(posedge ref_clk);
		miscompares++;
		end_sim;
	end

	initial begin
		int   n;
		logic seen;
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 9'h000;
		reg_raddr = 7'h00;
		static_gain_left = `AGC_GAIN_0DB;
		static_gain_right = `AGC_GAIN_0DB;
		{peak_over_left, peak_over_right, overload_left, overload_right} = 4'h0;
		{zero_cross_left, zero_cross_right} = 2'b00;
		checked = 0;
		miscompares = 0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		for (int i = 0; i < 6; i++)
			rd(ra[i], rv[i]);
		wr(`AGC_ADDR_RAMP, 9'h045);
		rd(`AGC_ADDR_RAMP, 9'h045);
		wr(`AGC_ADDR_RESET, 9'h000);
		rd(`AGC_ADDR_RAMP, `AGC_RST_RAMP);
		// Limiter, shortest window, then window off
		wr(`AGC_ADDR_LIMW, 9'h016);
		wr(`AGC_ADDR_RAMP, 9'h000);
		wr(`AGC_ADDR_CFG2, 9'h100);
		peak_over_left <= 1'b1;
		seen = 1'b0;
		repeat (1000) begin
			@(posedge ref_clk);
			seen = seen | ramping_down;
		end
		chk("burst ignored", 16'h0000, {15'h0000, seen});
		peak_over_left <= 1'b0;
		wr(`AGC_ADDR_LIMW, 9'h006);
		peak_over_left <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk("down flag", 16'h0001, {15'h0000, ramping_down});
		count_until_change(`AGC_GAIN_0DB, 6000, n);
		chk_span("attack gap", 5197, 5210, n);
		chk("left gain", 16'h00CE, {8'h00, pga_gain_left});
		chk("right gain", 16'h00CE, {8'h00, pga_gain_right});
		peak_over_left <= 1'b0;
		repeat (8) @(posedge ref_clk);
		chk("up flag", 16'h0001, {15'h0000, ramping_up});
		count_until_change(8'hCE, 26000, n);
		chk_span("decay gap", 24995, 25015, n);
		chk("left back", 16'h00CF, {8'h00, pga_gain_left});
		chk("right back", 16'h00CF, {8'h00, pga_gain_right});
		// Stereo level control under overload, slow attack code
		wr(`AGC_ADDR_CFG2, 9'h000);
		overload_left <= 1'b1;
		overload_right <= 1'b1;
		wr(`AGC_ADDR_CFG1, 9'h1FB);
		wr(`AGC_ADDR_RAMP, 9'h005);
		wr(`AGC_ADDR_CFG2, 9'h100);
		count_until_change(`AGC_GAIN_0DB, 27000, n);
		chk_span("overload gap", 25910, 25935, n);
		chk("right level", 16'h00CE, {8'h00, pga_gain_right});
		overload_left <= 1'b0;
		overload_right <= 1'b0;
		wr(`AGC_ADDR_CFG2, 9'h000);
		static_gain_left <= 8'hD0;
		repeat (6) @(posedge ref_clk);
		chk("follow static", 16'h00D0, {8'h00, pga_gain_left});
		// Right-only level control leaves the left gain to software
		wr(`AGC_ADDR_CFG1, 9'h0FB);
		wr(`AGC_ADDR_CFG2, 9'h100);
		static_gain_left <= 8'hD1;
		repeat (8) @(posedge ref_clk);
		chk("left free", 16'h00D1, {8'h00, pga_gain_left});
		chk("alc up flag", 16'h0001, {15'h0000, ramping_up});
		end_sim;
	end
endmodule
`default_nettype wire
